// ==== flash_protect_pkg.sv ====
package flash_protect_pkg;

    // ****************************************************************
    // Array geometry
    // ****************************************************************
    localparam int ADDR_W = 23;
    localparam logic [4:0] PAGE_LOG2 = 5'h08;
    localparam logic [4:0] SECTOR_LOG2 = 5'h0c;
    localparam logic [4:0] BLOCK32_LOG2 = 5'h0f;
    localparam logic [4:0] BLOCK64_LOG2 = 5'h10;
    localparam logic [4:0] CHIP_LOG2 = 5'h17;
    localparam int SEC_REG_SEL_LSB = 12;

    // ****************************************************************
    // Protect decode
    // ****************************************************************
    localparam logic [2:0] BP_NONE = 3'h0;
    localparam logic [2:0] BP_ALL = 3'h7;
    localparam logic [4:0] PROT_BLOCK_BASE_LOG2 = 5'h10;
    localparam logic [4:0] PROT_SECTOR_BASE_LOG2 = 5'h0b;
    localparam logic [4:0] PROT_SECTOR_MAX_LOG2 = 5'h0f;

    // ****************************************************************
    // Opcodes
    // ****************************************************************
    localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OPC_WRITE_STATUS = 8'h01;
    localparam logic [7:0] OPC_ENTER_QUAD = 8'h38;
    localparam logic [7:0] OPC_EXIT_QUAD = 8'hff;
    localparam logic [7:0] OPC_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] OPC_QUAD_PROGRAM = 8'h32;
    localparam logic [7:0] OPC_SECTOR_ERASE = 8'h20;
    localparam logic [7:0] OPC_BLOCK32_ERASE = 8'h52;
    localparam logic [7:0] OPC_BLOCK64_ERASE = 8'hd8;
    localparam logic [7:0] OPC_CHIP_ERASE = 8'hc7;
    localparam logic [7:0] OPC_CHIP_ERASE_ALT = 8'h60;
    localparam logic [7:0] OPC_SEC_REG_ERASE = 8'h44;
    localparam logic [7:0] OPC_SEC_REG_PROGRAM = 8'h42;

    // ****************************************************************
    // Status word bit positions
    // ****************************************************************
    localparam int SR_WEL = 1;
    localparam int SR_BP_LSB = 2;
    localparam int SR_TB = 5;
    localparam int SR_SEC = 6;
    localparam int SR_SRP0 = 7;
    localparam int SR_HI_BASE = 8;
    localparam int SR_SRP1 = 8;
    localparam int SR_QE = 9;
    localparam int SR_LOCK_LSB = 10;
    localparam int SR_CMP = 14;

    // ****************************************************************
    // Operation kinds shown to the array
    // ****************************************************************
    localparam logic [2:0] KIND_PROGRAM = 3'h0;
    localparam logic [2:0] KIND_SECTOR_ERASE = 3'h1;
    localparam logic [2:0] KIND_BLOCK32_ERASE = 3'h2;
    localparam logic [2:0] KIND_BLOCK64_ERASE = 3'h3;
    localparam logic [2:0] KIND_CHIP_ERASE = 3'h4;
    localparam logic [2:0] KIND_SEC_ERASE = 3'h5;
    localparam logic [2:0] KIND_SEC_PROGRAM = 3'h6;

    // ****************************************************************
    // Register map (byte addresses) and reset values
    // ****************************************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_RANGE_LO = 8'h08;
    localparam logic [7:0] REG_RANGE_HI = 8'h0c;
    localparam logic [7:0] REG_COUNTS = 8'h10;
    localparam logic [7:0] REG_LAST_OP = 8'h14;
    localparam logic CTRL_ENABLE_RESET = 1'b1;

endpackage

// ==== flash_write_protect.sv ====
module flash_write_protect (
    // Clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_reset_n,
    // AHB-Lite slave
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic             o_hreadyout,
    output logic             o_hresp,
    output logic [31:0]      o_hrdata,
    // Serial link pins
    input  wire logic        i_spi_clk,
    input  wire logic        i_spi_cs_n,
    input  wire logic [3:0]  i_spi_io,
    // Array operation handoff
    output logic             o_op_valid,
    output logic             o_op_rejected,
    output logic [2:0]       o_op_kind,
    output logic [22:0]      o_op_addr,
    // Pin function state
    output logic             o_io23_are_data,
    output logic             o_four_wire_mode,
    output logic             o_hold_active
);

    typedef enum logic {LINK_IDLE, LINK_ACTIVE} link_e;

    typedef struct packed {
        logic        sclk_meta;
        logic        sclk_sync;
        logic        sclk_prev;
        logic        cs_meta;
        logic        cs_sync;
        logic        cs_prev;
        logic [3:0]  io_meta;
        logic [3:0]  io_sync;
        link_e       link;
        logic [7:0]  shift;
        logic [2:0]  bit_cnt;
        logic [2:0]  byte_cnt;
        logic [7:0]  opcode;
        logic [23:0] addr;
        logic [7:0]  sr_lo;
        logic [7:0]  sr_hi;
        logic [2:0]  bp;
        logic        tb;
        logic        sec;
        logic        srp0;
        logic        srp1;
        logic        qe;
        logic [3:0]  lock;
        logic        cmp;
        logic        write_enable_latch;
        logic        four_wire;
        logic        op_valid;
        logic        op_rejected;
        logic        last_rejected;
        logic [2:0]  op_kind;
        logic [22:0] op_addr;
        logic [15:0] acc_cnt;
        logic [15:0] rej_cnt;
        logic        ctrl_enable;
        logic        d_active;
        logic        d_write;
        logic        d_mapped;
        logic [7:0]  d_addr;
    } state_s;

    state_s      s;
    state_s      next_s;

    logic        held;
    logic        sclk_rise;
    logic        cs_fall;
    logic        cs_rise;
    logic [3:0]  bit_sum;
    logic [7:0]  shift_in;
    logic        prot_any;
    logic [22:0] prot_lo;
    logic [22:0] prot_hi;
    logic [4:0]  region_log2;
    logic [2:0]  region_kind;
    logic        is_array_op;
    logic        is_sec_op;
    logic [2:0]  need_bytes;
    logic [22:0] region_mask;
    logic [22:0] region_lo;
    logic [22:0] region_hi;
    logic        overlap;
    logic        refuse;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [15:0] status_word(input state_s st);
        logic [15:0] w;
        w = '0;
        w[flash_protect_pkg::SR_WEL] = st.write_enable_latch;
        w[flash_protect_pkg::SR_BP_LSB +: 3] = st.bp;
        w[flash_protect_pkg::SR_TB] = st.tb;
        w[flash_protect_pkg::SR_SEC] = st.sec;
        w[flash_protect_pkg::SR_SRP0] = st.srp0;
        w[flash_protect_pkg::SR_SRP1] = st.srp1;
        w[flash_protect_pkg::SR_QE] = st.qe;
        w[flash_protect_pkg::SR_LOCK_LSB +: 4] = st.lock;
        w[flash_protect_pkg::SR_CMP] = st.cmp;
        return w;
    endfunction

    // Decode always reads the stored bits, so a status update governs the next command
    protect_range_decode u_decode (
        .i_sec (s.sec),
        .i_tb  (s.tb),
        .i_bp  (s.bp),
        .i_cmp (s.cmp),
        .o_any (prot_any),
        .o_lo  (prot_lo),
        .o_hi  (prot_hi)
    );

    // ****************************************************************
    // Command classification and overlap check
    // ****************************************************************
    always_comb begin
        region_log2 = flash_protect_pkg::PAGE_LOG2;
        region_kind = flash_protect_pkg::KIND_PROGRAM;
        is_array_op = 1'b1;
        is_sec_op = 1'b0;
        need_bytes = 3'h4;
        case (s.opcode)
            flash_protect_pkg::OPC_PAGE_PROGRAM,
            flash_protect_pkg::OPC_QUAD_PROGRAM: begin
                region_log2 = flash_protect_pkg::PAGE_LOG2;
            end
            flash_protect_pkg::OPC_SECTOR_ERASE: begin
                region_log2 = flash_protect_pkg::SECTOR_LOG2;
                region_kind = flash_protect_pkg::KIND_SECTOR_ERASE;
            end
            flash_protect_pkg::OPC_BLOCK32_ERASE: begin
                region_log2 = flash_protect_pkg::BLOCK32_LOG2;
                region_kind = flash_protect_pkg::KIND_BLOCK32_ERASE;
            end
            flash_protect_pkg::OPC_BLOCK64_ERASE: begin
                region_log2 = flash_protect_pkg::BLOCK64_LOG2;
                region_kind = flash_protect_pkg::KIND_BLOCK64_ERASE;
            end
            flash_protect_pkg::OPC_CHIP_ERASE,
            flash_protect_pkg::OPC_CHIP_ERASE_ALT: begin
                region_log2 = flash_protect_pkg::CHIP_LOG2;
                region_kind = flash_protect_pkg::KIND_CHIP_ERASE;
                need_bytes = 3'h1;
            end
            flash_protect_pkg::OPC_SEC_REG_ERASE: begin
                region_kind = flash_protect_pkg::KIND_SEC_ERASE;
                is_sec_op = 1'b1;
            end
            flash_protect_pkg::OPC_SEC_REG_PROGRAM: begin
                region_kind = flash_protect_pkg::KIND_SEC_PROGRAM;
                is_sec_op = 1'b1;
            end
            default: begin
                is_array_op = 1'b0;
            end
        endcase
        region_mask = ~({23{1'b1}} << region_log2);
        region_lo = s.addr[22:0] & ~region_mask;
        region_hi = s.addr[22:0] | region_mask;
        overlap = prot_any && (region_lo <= prot_hi) && (region_hi >= prot_lo);
        refuse = is_sec_op ? s.lock[s.addr[flash_protect_pkg::SEC_REG_SEL_LSB +: 2]]
                           : overlap;
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_s = s;
        next_s.op_valid = 1'b0;
        next_s.op_rejected = 1'b0;

        // Pins cross in through two flops; clock and select edges compare the second stage with a third flop
        next_s.sclk_meta = i_spi_clk;
        next_s.sclk_sync = s.sclk_meta;
        next_s.sclk_prev = s.sclk_sync;
        next_s.cs_meta = i_spi_cs_n;
        next_s.cs_sync = s.cs_meta;
        next_s.cs_prev = s.cs_sync;
        next_s.io_meta = i_spi_io;
        next_s.io_sync = s.io_meta;

        held = !s.qe && !s.io_sync[3];
        sclk_rise = s.sclk_sync && !s.sclk_prev && !s.cs_sync && !held && (s.link == LINK_ACTIVE);
        cs_fall = !s.cs_sync && s.cs_prev;
        cs_rise = s.cs_sync && !s.cs_prev;
        bit_sum = {1'b0, s.bit_cnt} + (s.four_wire ? 4'h4 : 4'h1);
        shift_in = s.four_wire ? {s.shift[3:0], s.io_sync} : {s.shift[6:0], s.io_sync[0]};

        // ****************************************************************
        // Register writes (data phase)
        // ****************************************************************
        if (s.d_active && s.d_write && s.d_mapped) begin
            case (s.d_addr)
                flash_protect_pkg::REG_CTRL: begin
                    next_s.ctrl_enable = i_hwdata[0];
                end
                flash_protect_pkg::REG_COUNTS: begin
                    // Cleared first so a same-cycle count still lands
                    next_s.acc_cnt = '0;
                    next_s.rej_cnt = '0;
                end
                default: begin
                end
            endcase
        end
        next_s.d_active = i_hsel && i_htrans[1] && i_hready;
        next_s.d_write = i_hwrite;
        next_s.d_mapped = (i_haddr[31:8] == 24'h0) && (i_haddr[1:0] == 2'h0);
        next_s.d_addr = i_haddr[7:0];

        // ****************************************************************
        // Link framing
        // ****************************************************************
        if (cs_fall && s.ctrl_enable) begin
            next_s.link = LINK_ACTIVE;
            next_s.bit_cnt = '0;
            next_s.byte_cnt = '0;
        end
        if (sclk_rise) begin
            next_s.shift = shift_in;
            next_s.bit_cnt = bit_sum[2:0];
            if (bit_sum[3]) begin
                case (s.byte_cnt)
                    3'h0: next_s.opcode = shift_in;
                    3'h1: next_s.sr_lo = shift_in;
                    3'h2: next_s.sr_hi = shift_in;
                    default: begin
                    end
                endcase
                if (s.byte_cnt >= 3'h1 && s.byte_cnt <= 3'h3) begin
                    next_s.addr = {s.addr[15:0], shift_in};
                end
                if (s.byte_cnt != 3'h7) begin
                    next_s.byte_cnt = s.byte_cnt + 3'h1;
                end
            end
        end

        // ****************************************************************
        // Command execution at frame end, whole bytes only
        // ****************************************************************
        if (cs_rise && s.link == LINK_ACTIVE) begin
            next_s.link = LINK_IDLE;
            if (s.bit_cnt == 3'h0 && s.byte_cnt != 3'h0) begin
                case (s.opcode)
                    flash_protect_pkg::OPC_WRITE_ENABLE: begin
                        next_s.write_enable_latch = 1'b1;
                    end
                    flash_protect_pkg::OPC_WRITE_DISABLE: begin
                        next_s.write_enable_latch = 1'b0;
                    end
                    flash_protect_pkg::OPC_WRITE_STATUS: begin
                        if (s.write_enable_latch && s.byte_cnt >= 3'h2) begin
                            next_s.bp = s.sr_lo[flash_protect_pkg::SR_BP_LSB +: 3];
                            next_s.tb = s.sr_lo[flash_protect_pkg::SR_TB];
                            next_s.sec = s.sr_lo[flash_protect_pkg::SR_SEC];
                            next_s.srp0 = s.sr_lo[flash_protect_pkg::SR_SRP0];
                            if (s.byte_cnt >= 3'h3) begin
                                next_s.srp1 = s.sr_hi[flash_protect_pkg::SR_SRP1 - flash_protect_pkg::SR_HI_BASE];
                                next_s.qe = s.sr_hi[flash_protect_pkg::SR_QE - flash_protect_pkg::SR_HI_BASE]
                                          || s.four_wire;
                                next_s.lock = s.lock
                                    | s.sr_hi[flash_protect_pkg::SR_LOCK_LSB - flash_protect_pkg::SR_HI_BASE +: 4];
                                next_s.cmp = s.sr_hi[flash_protect_pkg::SR_CMP - flash_protect_pkg::SR_HI_BASE];
                            end
                        end
                        if (s.byte_cnt >= 3'h2) begin
                            next_s.write_enable_latch = 1'b0;
                        end
                    end
                    flash_protect_pkg::OPC_ENTER_QUAD: begin
                        if (s.qe) begin
                            next_s.four_wire = 1'b1;
                        end
                    end
                    flash_protect_pkg::OPC_EXIT_QUAD: begin
                        next_s.four_wire = 1'b0;
                    end
                    default: begin
                        if (is_array_op && s.write_enable_latch && s.byte_cnt >= need_bytes) begin
                            next_s.write_enable_latch = 1'b0;
                            next_s.op_valid = !refuse;
                            next_s.op_rejected = refuse;
                            next_s.last_rejected = refuse;
                            next_s.op_kind = region_kind;
                            next_s.op_addr = is_sec_op ? s.addr[22:0] : region_lo;
                            if (refuse) begin
                                next_s.rej_cnt = next_s.rej_cnt + 16'h1;
                            end else begin
                                next_s.acc_cnt = next_s.acc_cnt + 16'h1;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s <= '0;
            s.cs_meta <= 1'b1;
            s.cs_sync <= 1'b1;
            s.cs_prev <= 1'b1;
            // Hold pin idles high, so no false hold right after reset
            s.io_meta <= 4'hf;
            s.io_sync <= 4'hf;
            s.ctrl_enable <= flash_protect_pkg::CTRL_ENABLE_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    always_comb begin
        o_hrdata = '0;
        if (s.d_active && !s.d_write && s.d_mapped) begin
            case (s.d_addr)
                flash_protect_pkg::REG_CTRL:     o_hrdata = {31'h0, s.ctrl_enable};
                flash_protect_pkg::REG_STATUS:   o_hrdata = {15'h0, s.four_wire, status_word(s)};
                flash_protect_pkg::REG_RANGE_LO: o_hrdata = {prot_any, 8'h0, prot_lo};
                flash_protect_pkg::REG_RANGE_HI: o_hrdata = {9'h0, prot_hi};
                flash_protect_pkg::REG_COUNTS:   o_hrdata = {s.rej_cnt, s.acc_cnt};
                flash_protect_pkg::REG_LAST_OP:  o_hrdata = {s.last_rejected, 4'h0, s.op_kind, 1'b0, s.op_addr};
                default:                         o_hrdata = '0;
            endcase
        end
    end

    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign o_op_valid = s.op_valid;
    assign o_op_rejected = s.op_rejected;
    assign o_op_kind = s.op_kind;
    assign o_op_addr = s.op_addr;
    assign o_io23_are_data = s.qe;
    assign o_four_wire_mode = s.four_wire;
    assign o_hold_active = held;

endmodule

// ==== flash_write_protect_sva.sv ====
module flash_write_protect_sva (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_spi_cs_n,
    input wire logic [3:0] i_spi_io,
    input wire logic o_op_valid,
    input wire logic o_op_rejected,
    input wire logic o_io23_are_data,
    input wire logic o_four_wire_mode,
    input wire logic o_hold_active
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_reset_n);
    wire op = o_op_valid || o_op_rejected;
    a_op_after_cs: assert property (op |-> $past(i_spi_cs_n, 2)) else $error("op inside frame");
    a_op_one_kind: assert property (!(o_op_valid && o_op_rejected)) else $error("op both");
    a_op_pulse: assert property (op |=> !op) else $error("op pulse long");
    a_quad_gates: assert property ($rose(o_four_wire_mode) |-> $past(o_io23_are_data)) else $error("mode");
    a_quad_after_cs: assert property ($rose(o_four_wire_mode) |-> $past(i_spi_cs_n)) else $error("mode");
    a_quad_kept: assert property (o_four_wire_mode |-> o_io23_are_data) else $error("quad lost");
    a_quad_no_drop: assert property ($fell(o_io23_are_data) |-> !$past(o_four_wire_mode)) else $error("drop");
    a_hold_off: assert property (o_hold_active |-> !o_io23_are_data && !$past(i_spi_io[3], 2)) else $error("hold");
    cover property (o_op_rejected);
    cover property (o_op_valid);
    cover property ($rose(o_four_wire_mode));
endmodule

bind flash_write_protect flash_write_protect_sva flash_write_protect_sva_i (.*);

// ==== flash_write_protect_tb.sv ====
module flash_write_protect_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk  = 1'b0;
    logic        reset_n  = 1'b0;
    logic [31:0] haddr    = 32'h0;
    logic [1:0]  htrans   = 2'h0;
    logic        hwrite   = 1'b0;
    logic [31:0] hwdata   = 32'h0;
    logic        hresp;
    logic [2:0]  op_kind;
    logic [22:0] op_addr;
    // Bit 2 hold active, bit 1 shared pins are data, bit 0 four-wire mode
    wire  [2:0]  pins;
    logic        hready;
    logic [31:0] hrdata;
    logic        sclk;
    logic        cs_n;
    logic [3:0]  io;
    int          n_fail   = 0;
    int          compares = 0;
    logic [61:0] tbl [7] = '{{16'h0404, 23'h7e0000, 23'h7fffff}, {16'h2400, 23'h0, 23'h01ffff},
        {16'h4400, 23'h7ff000, 23'h7fffff}, {16'h7400, 23'h0, 23'h007fff}, {16'h1c00, 23'h0, 23'h7fffff},
        {16'h0440, 23'h0, 23'h7dffff}, {16'h0400, 23'h7e0000, 23'h7fffff}};
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    flash_write_protect flash_write_protect_i (.i_sys_clk(sys_clk), .i_reset_n(reset_n), .i_hsel(1'b1),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
        .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata), .i_spi_clk(sclk), .i_spi_cs_n(cs_n), .i_spi_io(io),
        .o_op_valid(), .o_op_rejected(), .o_op_kind(op_kind), .o_op_addr(op_addr), .o_io23_are_data(pins[1]),
        .o_four_wire_mode(pins[0]), .o_hold_active(pins[2]));
    spi_host_model spi_host_model_i (.i_sys_clk(sys_clk), .o_sclk(sclk), .o_cs_n(cs_n), .o_io(io));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // For a write, exp is the write data
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] exp);
        @(posedge sys_clk);
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge sys_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= w ? exp : 32'h0;
        do @(posedge sys_clk); while (hready !== 1'b1);
        if (!w) chk(hrdata, exp);
        chk({31'h0, hresp}, 32'h0);
    endtask
    task automatic cmd(input logic [31:0] d, input int n);
        spi_host_model_i.frame(32'h06, 1);
        spi_host_model_i.frame(d, n);
    endtask
    task automatic t_reset();
        bus(8'h04, 1'b0, 32'h0);
        bus(8'h08, 1'b0, 32'h0);
        bus(8'h20, 1'b0, 32'h0);
        bus(8'h00, 1'b0, 32'h1);
        // With the link disabled a write enable must not reach the latch
        bus(8'h00, 1'b1, 32'h0);
        spi_host_model_i.frame(32'h06, 1);
        bus(8'h04, 1'b0, 32'h0);
        bus(8'h00, 1'b1, 32'h1);
        spi_host_model_i.frame(32'h38, 1);
        chk({29'h0, pins}, 32'h4);
        bus(8'h04, 1'b0, 32'h0);
    endtask
    task automatic t_decode();
        for (int k = 0; k < 7; k++) begin
            cmd({8'h01, tbl[k][61:46]}, 3);
            bus(8'h08, 1'b0, {1'b1, 8'h0, tbl[k][45:23]});
            bus(8'h0c, 1'b0, {9'h0, tbl[k][22:0]});
        end
        bus(8'h04, 1'b0, 32'h0404);
    endtask
    task automatic t_ops();
        cmd({8'h20, 24'h7e0000}, 4);
        bus(8'h14, 1'b0, 32'h817e0000);
        chk({6'h0, op_kind, op_addr}, {6'h0, 3'h1, 23'h7e0000});
        cmd({8'h20, 24'h7d0000}, 4);
        bus(8'h14, 1'b0, 32'h017d0000);
        cmd({8'h42, 24'h000000}, 4);
        bus(8'h14, 1'b0, 32'h86000000);
        chk({6'h0, op_kind, op_addr}, {6'h0, 3'h6, 23'h0});
        bus(8'h10, 1'b0, 32'h00020001);
        bus(8'h10, 1'b1, 32'h0);
        bus(8'h10, 1'b0, 32'h0);
    endtask
    task automatic t_quad();
        cmd({8'h01, 16'h0402}, 3);
        bus(8'h04, 1'b0, 32'h0604);
        spi_host_model_i.frame(32'h38, 1);
        bus(8'h04, 1'b0, 32'h10604);
        chk({29'h0, pins}, 32'h3);
        spi_host_model_i.quad = 1'b1;
        cmd({8'h01, 16'h0400}, 3);
        bus(8'h04, 1'b0, 32'h10604);
        spi_host_model_i.frame(32'hff, 1);
        spi_host_model_i.quad = 1'b0;
        cmd({8'h01, 16'h0400}, 3);
        bus(8'h04, 1'b0, 32'h0404);
        chk({29'h0, pins}, 32'h4);
    endtask
    task automatic final_report();
        if (n_fail == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        t_reset();
        t_decode();
        t_ops();
        t_quad();
        final_report();
    end
    initial begin
        #600us;
        n_fail++;
        final_report();
    end
endmodule

// ==== protect_range_decode.sv ====
module protect_range_decode (
    // Stored protect bits
    input  wire logic        i_sec,
    input  wire logic        i_tb,
    input  wire logic [2:0]  i_bp,
    input  wire logic        i_cmp,
    // Protected range, inclusive
    output logic             o_any,
    output logic [22:0]      o_lo,
    output logic [22:0]      o_hi
);

    logic [4:0]  size_log2;
    logic [22:0] mask;
    logic        base_any;
    logic [22:0] base_lo;
    logic [22:0] base_hi;

    always_comb begin
        if (i_sec) begin
            // Codes 10x and 110 all cap at the 32KB size
            size_log2 = flash_protect_pkg::PROT_SECTOR_BASE_LOG2 + {2'h0, i_bp};
            if (size_log2 > flash_protect_pkg::PROT_SECTOR_MAX_LOG2) begin
                size_log2 = flash_protect_pkg::PROT_SECTOR_MAX_LOG2;
            end
        end else begin
            size_log2 = flash_protect_pkg::PROT_BLOCK_BASE_LOG2 + {2'h0, i_bp};
        end
        mask = ~({23{1'b1}} << size_log2);
        base_any = 1'b1;
        base_lo = '0;
        base_hi = '1;
        if (i_bp == flash_protect_pkg::BP_NONE) begin
            base_any = 1'b0;
        end else if (i_bp == flash_protect_pkg::BP_ALL) begin
            base_lo = '0;
            base_hi = '1;
        end else if (!i_tb) begin
            base_lo = ~mask;
            base_hi = '1;
        end else begin
            base_lo = '0;
            base_hi = mask;
        end
        // A top or bottom span inverts into the other contiguous span
        o_any = base_any;
        o_lo = base_lo;
        o_hi = base_hi;
        if (i_cmp) begin
            if (!base_any) begin
                o_any = 1'b1;
                o_lo = '0;
                o_hi = '1;
            end else if (i_bp == flash_protect_pkg::BP_ALL) begin
                o_any = 1'b0;
            end else if (!i_tb) begin
                o_lo = '0;
                o_hi = base_lo - 23'h1;
            end else begin
                o_lo = base_hi + 23'h1;
                o_hi = '1;
            end
        end
    end

endmodule

// ==== spi_host_model.sv ====
module spi_host_model (
    input  wire logic       i_sys_clk,
    output logic            o_sclk,
    output logic            o_cs_n,
    output logic [3:0]      o_io
);
    timeunit 1ns;
    timeprecision 1ps;
    logic quad = 1'b0;
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_io   = 4'hf;
    end
    // Link clock of 80 ns, parked low outside frames; bytes go MSB first
    task automatic frame(input logic [31:0] d, input int n);
        @(posedge i_sys_clk);
        o_cs_n <= 1'b0;
        for (int i = n * 8 - 1; i >= 0; i -= (quad ? 4 : 1)) begin
            o_io <= quad ? d[i -: 4] : {3'h7, d[i]};
            repeat (4) @(posedge i_sys_clk);
            o_sclk <= 1'b1;
            repeat (4) @(posedge i_sys_clk);
            o_sclk <= 1'b0;
        end
        repeat (4) @(posedge i_sys_clk);
        o_cs_n <= 1'b1;
        // Released lines must not keep showing the last bit
        o_io   <= ~o_io;
        repeat (8) @(posedge i_sys_clk);
    endtask
endmodule
